// ---- hw/rpsm_defs.svh ----
// Purpose: Constants for the remappable pin select multiplexer
// Assumes: Included by the pin select design only
// Notes:   Output codes are six bits, input selector codes are eight bits
`ifndef RPSM_DEFS_SVH
`define RPSM_DEFS_SVH

`define RPSM_OSEL_W          6
`define RPSM_ISEL_W          8
`define RPSM_OSEL_RESET      6'h00
`define RPSM_ISEL_RESET      8'h00
`define RPSM_OUT_DEFAULT     6'h00
`define RPSM_OUT_UART1_TX    6'h01
`define RPSM_OUT_UART2_TX    6'h03
`define RPSM_OUT_SPI2_DO     6'h08
`define RPSM_OUT_SPI2_CK     6'h09
`define RPSM_OUT_SPI2_SS     6'h0a
`define RPSM_OUT_CAN1_TX     6'h0e
`define RPSM_OUT_OCMP1       6'h10
`define RPSM_OUT_OCMP2       6'h11
`define RPSM_OUT_OCMP3       6'h12
`define RPSM_OUT_OCMP4       6'h13
`define RPSM_OUT_CMP1        6'h18
`define RPSM_OUT_CMP2        6'h19
`define RPSM_OUT_CMP3        6'h1a
`define RPSM_OUT_PWM_SYNC    6'h2d
`define RPSM_OUT_REFCLK      6'h31
`define RPSM_OUT_CMP4        6'h32
`define RPSM_OUT_CMP5        6'h33
`define RPSM_OUT_SENT1       6'h39
`define RPSM_OUT_SENT2       6'h3a
`define RPSM_IN_VIRT_FIRST   8'hb0
`define RPSM_IN_VIRT_LAST    8'hb5
`define RPSM_DEC_NONE        6'h00
`define RPSM_DEC_VALID       5
`define RPSM_SRC_IDX_W       5
`define RPSM_IN_BANK_BIT     7
`define RPSM_PIN_IDX_W       7
`define RPSM_VIRT_IDX_W      3
`define RPSM_IN_NONE         1'b0
`define RPSM_FLOAT_DATA      1'b0
`define RPSM_FLOAT_OE        1'b0
`define RPSM_PIN_OUT_RESET   1'b0
`define RPSM_PIN_OE_RESET    1'b0
`define RPSM_PERIPH_IN_RESET 1'b0

`endif

// ---- hw/rpsm_mux.sv ----
// Purpose: Peripheral pin select multiplexer, input and output routing
// Assumes: All inputs synchronous to mclk; selectors written by software as plain ports
// Notes:   Selector values are registered; pin outputs are flopped data
//
// Functional notes
// (R1) Each remappable pin has a field naming the one peripheral output driving it.
// (R2) Output select fields are six bits, one per remappable pin.
// (R3) After reset every output field is zero, the null output.
// (R4) Code zero gives the pin its default port function.
// (R5) Code 000001 routes UART one transmit, 000011 UART two transmit.
// (R6) Codes 001000..001010 route SPI two data, clock, select outputs.
// (R7) Code 001110 routes CAN one transmit.
// (R8) Codes 010000..010011 route output compare one to four.
// (R9) Codes 011000..011010 route comparator outputs one to three.
// (R10) Codes 110010 and 110011 route comparator outputs four and five.
// (R11) Code 101101 routes the PWM time base sync output.
// (R12) Code 110001 routes the reference clock output.
// (R13) Codes 111001 and 111010 route SENT transmitters one and two.
// (R14) No interlock between mapping registers; any combination allowed.
// (R15) Each input selector picks a source pin by its code.
// (R16) Unimplemented input selector codes connect no pin.
// (R17) Input codes 10110000..10110101 select virtual pins 176 to 181.
// (R18) Core overvoltage detect tri-states every pin until it clears.
// (R19) Unassigned output codes leave the pin undriven by remappable outputs.
// (R20) An enabled dedicated output beats any remappable output.
// (R21) Active outputs override the direction register; remappable inputs do not.
`default_nettype none
`include "rpsm_defs.svh"

module rpsm_mux #(
	parameter int NUM_PINS  = 8,
	parameter int NUM_INSEL = 4,
	// Bit k high means input code k is a real pin; codes above 0x7f
	// other than virtual ones are treated as unimplemented
	parameter logic [127:0] PIN_IMPL = {128{1'b1}}
) (
	// Clock and reset
	input  wire logic                                 mclk,
	input  wire logic                                 reset,
	// Selector programming
	input  wire logic [NUM_PINS*`RPSM_OSEL_W-1:0]     pin_output_select_field,
	input  wire logic [NUM_INSEL*`RPSM_ISEL_W-1:0]    peripheral_input_select_register,
	// Peripheral outputs, indexed by rpsm_pkg::rpsm_src_e
	input  wire logic [rpsm_pkg::RPSM_NUM_SRC-1:0]    periph_out,
	// Port logic per pin
	input  wire logic [NUM_PINS-1:0]                  port_data_out,
	input  wire logic [NUM_PINS-1:0]                  pin_direction_register,
	input  wire logic [NUM_PINS-1:0]                  dedicated_out_en,
	input  wire logic [NUM_PINS-1:0]                  dedicated_out_data,
	input  wire logic                                 core_overvoltage_detect,
	// Pin side; code k of the input selector names pin k
	input  wire logic [127:0]                         pin_in,
	input  wire logic [5:0]                           virtual_pin_in,
	output logic      [NUM_PINS-1:0]                  pin_out,
	output logic      [NUM_PINS-1:0]                  pin_oe,
	// Peripheral input side
	output logic      [NUM_INSEL-1:0]                 periph_in
);

	// Map an output code to a source index; valid low for null or unlisted codes
	function automatic logic [5:0] decode_out(input logic [`RPSM_OSEL_W-1:0] code);
		logic [5:0] r;
		r = `RPSM_DEC_NONE;
		case (code)
			`RPSM_OUT_UART1_TX: r = {1'b1, rpsm_pkg::RPSM_SRC_UART1_TX}; // see (R5)
			`RPSM_OUT_UART2_TX: r = {1'b1, rpsm_pkg::RPSM_SRC_UART2_TX}; // see (R5)
			`RPSM_OUT_SPI2_DO:  r = {1'b1, rpsm_pkg::RPSM_SRC_SPI2_DO};  // see (R6)
			`RPSM_OUT_SPI2_CK:  r = {1'b1, rpsm_pkg::RPSM_SRC_SPI2_CK};  // see (R6)
			`RPSM_OUT_SPI2_SS:  r = {1'b1, rpsm_pkg::RPSM_SRC_SPI2_SS};  // see (R6)
			`RPSM_OUT_CAN1_TX:  r = {1'b1, rpsm_pkg::RPSM_SRC_CAN1_TX};  // see (R7)
			`RPSM_OUT_OCMP1:    r = {1'b1, rpsm_pkg::RPSM_SRC_OCMP1};    // see (R8)
			`RPSM_OUT_OCMP2:    r = {1'b1, rpsm_pkg::RPSM_SRC_OCMP2};    // see (R8)
			`RPSM_OUT_OCMP3:    r = {1'b1, rpsm_pkg::RPSM_SRC_OCMP3};    // see (R8)
			`RPSM_OUT_OCMP4:    r = {1'b1, rpsm_pkg::RPSM_SRC_OCMP4};    // see (R8)
			`RPSM_OUT_CMP1:     r = {1'b1, rpsm_pkg::RPSM_SRC_CMP1};     // see (R9)
			`RPSM_OUT_CMP2:     r = {1'b1, rpsm_pkg::RPSM_SRC_CMP2};     // see (R9)
			`RPSM_OUT_CMP3:     r = {1'b1, rpsm_pkg::RPSM_SRC_CMP3};     // see (R9)
			`RPSM_OUT_CMP4:     r = {1'b1, rpsm_pkg::RPSM_SRC_CMP4};     // see (R10)
			`RPSM_OUT_CMP5:     r = {1'b1, rpsm_pkg::RPSM_SRC_CMP5};     // see (R10)
			`RPSM_OUT_PWM_SYNC: r = {1'b1, rpsm_pkg::RPSM_SRC_PWM_SYNC}; // see (R11)
			`RPSM_OUT_REFCLK:   r = {1'b1, rpsm_pkg::RPSM_SRC_REFCLK};   // see (R12)
			`RPSM_OUT_SENT1:    r = {1'b1, rpsm_pkg::RPSM_SRC_SENT1};    // see (R13)
			`RPSM_OUT_SENT2:    r = {1'b1, rpsm_pkg::RPSM_SRC_SENT2};    // see (R13)
			default:            r = `RPSM_DEC_NONE; // Null or unlisted code, see (R4) (R19)
		endcase
		return r;
	endfunction

	// Map an input code to its pin level; zero when nothing is connected
	function automatic logic decode_in(input logic [`RPSM_ISEL_W-1:0] code,
			input logic [127:0] pins, input logic [5:0] vpins);
		logic       r;
		logic [7:0] vi;
		r  = `RPSM_IN_NONE;
		vi = code - `RPSM_IN_VIRT_FIRST;
		if (code >= `RPSM_IN_VIRT_FIRST && code <= `RPSM_IN_VIRT_LAST) begin
			r = vpins[vi[`RPSM_VIRT_IDX_W-1:0]]; // see (R17)
		end else if (!code[`RPSM_IN_BANK_BIT] && PIN_IMPL[code[`RPSM_PIN_IDX_W-1:0]]) begin
			r = pins[code[`RPSM_PIN_IDX_W-1:0]]; // see (R15)
		end else begin
			// A fixed low rather than a stray pin keeps unused inputs quiet
			r = `RPSM_IN_NONE; // Unimplemented selector, see (R16)
		end
		return r;
	endfunction

	logic [NUM_PINS*`RPSM_OSEL_W-1:0]  osel_q;
	logic [NUM_INSEL*`RPSM_ISEL_W-1:0] isel_q;

	// Selector registers; each field is independent, no cross checks
	always_ff @(posedge mclk) begin
		if (reset) begin
			osel_q <= {NUM_PINS{`RPSM_OSEL_RESET}}; // see (R3)
		end else begin
			osel_q <= pin_output_select_field; // see (R14)
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			isel_q <= {NUM_INSEL{`RPSM_ISEL_RESET}};
		end else begin
			isel_q <= peripheral_input_select_register; // see (R14)
		end
	end

	// Per-pin output path: one selected source per pin
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
			logic [5:0] dec;
			logic       remap_on;
			logic       remap_lvl;
			logic       out_d;
			logic       oe_d;
			logic       out_q;
			logic       oe_q;

			// Decode from the registered field only, so a half-written field never glitches
			assign dec       = decode_out(osel_q[gp*`RPSM_OSEL_W +: `RPSM_OSEL_W]); // see (R1) (R2)
			assign remap_on  = dec[`RPSM_DEC_VALID]; // see (R4) (R19)
			assign remap_lvl = periph_out[dec[`RPSM_SRC_IDX_W-1:0]]; // see (R1)

			// Priority: overvoltage, then dedicated, then remap, then port latch
			always_comb begin
				if (core_overvoltage_detect) begin
					// Everything floats while the core rail is unsafe
					out_d = `RPSM_FLOAT_DATA; // see (R18)
					oe_d  = `RPSM_FLOAT_OE; // see (R18)
				end else if (dedicated_out_en[gp]) begin
					out_d = dedicated_out_data[gp]; // see (R20)
					oe_d  = 1'b1; // see (R21)
				end else if (remap_on) begin
					out_d = remap_lvl; // see (R1)
					oe_d  = 1'b1; // Direction register overridden, see (R21)
				end else begin
					// Default port function follows the direction register
					out_d = port_data_out[gp]; // see (R4) (R19)
					oe_d  = ~pin_direction_register[gp]; // see (R21)
				end
			end

			// Pin data flop
			always_ff @(posedge mclk) begin
				if (reset) begin
					out_q <= `RPSM_PIN_OUT_RESET;
				end else begin
					out_q <= out_d;
				end
			end

			// Pin enable flop; reset leaves the pin floating
			always_ff @(posedge mclk) begin
				if (reset) begin
					oe_q <= `RPSM_PIN_OE_RESET;
				end else begin
					oe_q <= oe_d;
				end
			end

			assign pin_out[gp] = out_q;
			assign pin_oe[gp]  = oe_q;
		end
	endgenerate

	// Peripheral input path; many inputs may share one pin
	genvar gi;
	generate
		for (gi = 0; gi < NUM_INSEL; gi++) begin : g_in
			logic in_d;
			logic in_q;

			// Selected level; the pin itself adds one edge of latency
			assign in_d = decode_in(isel_q[gi*`RPSM_ISEL_W +: `RPSM_ISEL_W],
				pin_in, virtual_pin_in); // see (R14) (R15)

			always_ff @(posedge mclk) begin
				if (reset) begin
					in_q <= `RPSM_PERIPH_IN_RESET;
				end else begin
					in_q <= in_d;
				end
			end

			assign periph_in[gi] = in_q;
		end
	endgenerate

endmodule
`default_nettype wire

// ---- hw/rpsm_pkg.sv ----
// Purpose: Types for the remappable pin select multiplexer
// Assumes: Source indices and count are written out here, not taken from rpsm_defs.svh
// Notes:   Peripheral outputs are indexed by this enum in a flat vector
`default_nettype none
package rpsm_pkg;
	// Index of each remappable peripheral output in the source vector
	typedef enum logic [4:0] {
		RPSM_SRC_UART1_TX = 5'h00,
		RPSM_SRC_UART2_TX = 5'h01,
		RPSM_SRC_SPI2_DO  = 5'h02,
		RPSM_SRC_SPI2_CK  = 5'h03,
		RPSM_SRC_SPI2_SS  = 5'h04,
		RPSM_SRC_CAN1_TX  = 5'h05,
		RPSM_SRC_OCMP1    = 5'h06,
		RPSM_SRC_OCMP2    = 5'h07,
		RPSM_SRC_OCMP3    = 5'h08,
		RPSM_SRC_OCMP4    = 5'h09,
		RPSM_SRC_CMP1     = 5'h0a,
		RPSM_SRC_CMP2     = 5'h0b,
		RPSM_SRC_CMP3     = 5'h0c,
		RPSM_SRC_CMP4     = 5'h0d,
		RPSM_SRC_CMP5     = 5'h0e,
		RPSM_SRC_PWM_SYNC = 5'h0f,
		RPSM_SRC_REFCLK   = 5'h10,
		RPSM_SRC_SENT1    = 5'h11,
		RPSM_SRC_SENT2    = 5'h12
	} rpsm_src_e;
	localparam int RPSM_NUM_SRC = 19;
endpackage
`default_nettype wire

// ---- testbench/remappable_pin_select_mux_tb.sv ----
// Purpose: Directed bench for the pin select multiplexer
// Assumes: Inputs change on the falling edge only
// Notes:   Expected levels come from the far model's own outputs
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module remappable_pin_select_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, reset = 1, ovd = 0, flip = 0;
	logic [23:0] osel = '0;
	logic [15:0] isel = '0;
	logic [3:0]  pdo = '0, dir = '1, den = '0, dd = '0, pout, poe;
	logic [18:0] po;
	logic [127:0] pin;
	logic [5:0]  vp;
	logic [1:0]  pq;
	int          mismatches = 0, n_tests = 0;
	// Codes in source index order, then input codes incl. refused ones
	logic [5:0]  oc [19] = '{6'h01, 6'h03, 6'h08, 6'h09, 6'h0a, 6'h0e, 6'h10, 6'h11, 6'h12,
		6'h13, 6'h18, 6'h19, 6'h1a, 6'h32, 6'h33, 6'h2d, 6'h31, 6'h39, 6'h3a};
	logic [7:0]  ic [11] = '{8'h31, 8'h60, 8'h7f, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5,
		8'hb6, 8'hc0};
	rpsm_mux #(.NUM_PINS(4), .NUM_INSEL(2)) dut (.mclk(mclk), .reset(reset),
		.pin_output_select_field(osel), .peripheral_input_select_register(isel),
		.periph_out(po), .port_data_out(pdo), .pin_direction_register(dir),
		.dedicated_out_en(den), .dedicated_out_data(dd), .core_overvoltage_detect(ovd),
		.pin_in(pin), .virtual_pin_in(vp), .pin_out(pout), .pin_oe(poe), .periph_in(pq));
	rpsm_far_model u_far (.flip(flip), .periph_out(po), .pin_in(pin), .virtual_pin_in(vp));
	// Expected peripheral input level for one input code
	function automatic logic ie(input logic [7:0] c);
		if (!c[7]) return pin[c[6:0]];
		if (c >= 8'hb0 && c <= 8'hb5) return vp[c - 8'hb0];
		return 1'b0;
	endfunction
	task automatic step(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		forever begin
			#2.5 mclk = ~mclk;
		end
	end
	// Whole run needs well under 400 cycles
	initial begin
		repeat (2000) @(posedge mclk);
		mismatches++;
		stop_test();
	end
	initial begin
		step(3);
		reset = 0;
		`CHK("after reset", '0, {pout, poe, pq})
		for (int i = 0; i < 38; i++) begin
			osel[11:0] = {2{oc[i / 2]}};
			flip = i[0];
			step(3);
			`CHK("remap pin0", po[i / 2], pout[0])
			`CHK("remap pin1", po[i / 2], pout[1])
			`CHK("remap drive", 2'b11, poe[1:0])
		end
		pdo = 4'h5;
		dir = 4'he;
		for (int k = 0; k < 2; k++) begin
			osel[5:0] = k == 0 ? 6'h00 : 6'h02;
			step(3);
			`CHK("default pin", 3'b110, {pout[0], poe[0], poe[2]})
		end
		osel[5:0] = 6'h01;
		// Dedicated level opposite to the remapped source, so priority shows
		dd = 4'h1;
		den = 4'h1;
		step(3);
		`CHK("dedicated", 2'b11, {pout[0], poe[0]})
		ovd = 1;
		step(2);
		`CHK("overvoltage", '0, {pout, poe})
		ovd = 0;
		den = '0;
		step(2);
		`CHK("released", {po[0], 1'b1}, {pout[0], poe[0]})
		// Mid-run reset: first edge after it must still see the null field
		reset = 1;
		step(2);
		reset = 0;
		step(1);
		`CHK("null after reset", {pdo[0], 1'b1}, {pout[0], poe[0]})
		step(1);
		`CHK("remap after reset", {po[0], 1'b1}, {pout[0], poe[0]})
		for (int k = 0; k < 22; k++) begin
			isel = {2{ic[k / 2]}};
			flip = k[0];
			step(3);
			`CHK("input select", {2{ie(ic[k / 2])}}, pq)
		end
		stop_test();
	end
endmodule
`default_nettype wire

// ---- testbench/rpsm_far_model.sv ----
// Purpose: Far side model: peripheral outputs and pin levels
// Assumes: flip is driven by the bench on the falling edge
// Notes:   Fixed patterns; flip inverts them so stuck routes show
`default_nettype none
module rpsm_far_model (
	// Control
	input  wire logic         flip,
	// Driven levels
	output logic      [18:0]  periph_out,
	output logic      [127:0] pin_in,
	output logic      [5:0]   virtual_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Mixed ones and zeros so a wrong source usually differs
	assign periph_out = flip ? ~19'h2b4d3 : 19'h2b4d3;
	assign pin_in = {4{flip ? ~32'h9e3779b9 : 32'h9e3779b9}};
	assign virtual_pin_in = flip ? ~6'h25 : 6'h25;
endmodule
`default_nettype wire

// ---- testbench/rpsm_mux_assertions.sv ----
// Purpose: Port checks for the pin select multiplexer
// Assumes: Selector reaches pins in two edges, data in one
// Notes:   Pin 0 and peripheral input 0 are watched; the overvoltage check covers every pin
`default_nettype none
module rpsm_mux_chk #(
	parameter int NUM_PINS  = 8,
	parameter int NUM_INSEL = 4
) (
	// Clock and reset
	input wire logic                   mclk,
	input wire logic                   reset,
	// Inputs
	input wire logic [NUM_PINS*6-1:0]  pin_output_select_field,
	input wire logic [NUM_INSEL*8-1:0] peripheral_input_select_register,
	input wire logic [18:0]            periph_out,
	input wire logic [NUM_PINS-1:0]    pin_direction_register,
	input wire logic [NUM_PINS-1:0]    dedicated_out_en,
	input wire logic [NUM_PINS-1:0]    dedicated_out_data,
	input wire logic                   core_overvoltage_detect,
	input wire logic [127:0]           pin_in,
	input wire logic [5:0]             virtual_pin_in,
	// Outputs
	input wire logic [NUM_PINS-1:0]    pin_out,
	input wire logic [NUM_PINS-1:0]    pin_oe,
	input wire logic [NUM_INSEL-1:0]   periph_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] s0;
	logic [7:0] i0;
	logic [6:0] idx_q;
	logic       q0;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	// Field taps; q0 means nothing outranks the remap on pin 0
	assign s0 = pin_output_select_field[5:0];
	assign i0 = peripheral_input_select_register[7:0];
	assign q0 = !dedicated_out_en[0] && !core_overvoltage_detect;
	// Pin index one edge old, as the input path registers it
	always_ff @(posedge mclk) begin
		idx_q <= i0[6:0];
	end
	property p_hvd;
		core_overvoltage_detect |=> pin_oe == '0 && pin_out == '0;
	endproperty
	a_hvd: assert property (p_hvd) else $error("pins driven in overvoltage");
	property p_ded;
		dedicated_out_en[0] && !core_overvoltage_detect |=>
			pin_oe[0] && pin_out[0] == $past(dedicated_out_data[0]);
	endproperty
	a_ded: assert property (p_ded) else $error("dedicated output lost");
	property p_null;
		!$past(reset) && $past(s0) == 6'h00 && q0 |=>
			pin_oe[0] == !$past(pin_direction_register[0]);
	endproperty
	a_null: assert property (p_null) else $error("null code drives pin");
	property p_unas;
		!$past(reset) && $past(s0) == 6'h02 && q0 |=>
			pin_oe[0] == !$past(pin_direction_register[0]);
	endproperty
	a_unas: assert property (p_unas) else $error("unlisted code drives pin");
	property p_uart;
		!$past(reset) && $past(s0) == 6'h01 && q0 |=> pin_oe[0] && pin_out[0] == $past(periph_out[0]);
	endproperty
	a_uart: assert property (p_uart) else $error("transmit one not routed");
	property p_sent;
		!$past(reset) && $past(s0) == 6'h3a && q0 |=> pin_out[0] == $past(periph_out[18]);
	endproperty
	a_sent: assert property (p_sent) else $error("sent two not routed");
	property p_vpin;
		!$past(reset) && $past(i0) == 8'hb2 |=> periph_in[0] == $past(virtual_pin_in[2]);
	endproperty
	a_vpin: assert property (p_vpin) else $error("virtual pin not routed");
	property p_none;
		!$past(reset) && $past(i0) == 8'hc0 |=> !periph_in[0];
	endproperty
	a_none: assert property (p_none) else $error("unimplemented code passes");
	property p_pin;
		!$past(reset) && !$past(i0[7]) |=> periph_in[0] == $past(pin_in[idx_q]);
	endproperty
	a_pin: assert property (p_pin) else $error("wrong pin on input");
endmodule
bind rpsm_mux rpsm_mux_chk #(.NUM_PINS(NUM_PINS), .NUM_INSEL(NUM_INSEL)) u_chk (
	.mclk, .reset, .pin_output_select_field, .peripheral_input_select_register,
	.periph_out, .pin_direction_register, .dedicated_out_en, .dedicated_out_data,
	.core_overvoltage_detect, .pin_in, .virtual_pin_in, .pin_out, .pin_oe, .periph_in
);
`default_nettype wire
